// >>> hdl/spm_pkg.sv
package spm_pkg;

	// ****************************************
	// Map geometry and encodings
	// ****************************************
	localparam int          MAP_BYTES      = 16;
	localparam logic [7:0]  MAP_ERASED     = 8'hFF;
	localparam logic [7:0]  MAP_SHIPPED    = 8'h00;
	localparam logic [7:0]  OP_PREFIX_0    = 8'h3D;
	localparam logic [7:0]  OP_PREFIX_1    = 8'h2A;
	localparam logic [7:0]  OP_PREFIX_2    = 8'h7F;
	localparam logic [7:0]  OP_MAP_ERASE   = 8'hCF;
	localparam logic [7:0]  OP_MAP_PROGRAM = 8'hFC;
	localparam logic [7:0]  OP_MAP_READ    = 8'h32;
	localparam int          READ_DUMMIES   = 3;
	localparam int          SUB0A_HI       = 7;
	localparam int          SUB0A_LO       = 6;
	localparam int          SUB0B_HI       = 5;
	localparam int          SUB0B_LO       = 4;

	// ****************************************
	// Timing
	// ****************************************
	localparam int          CLK_PERIOD_NS          = 10;
	localparam int          MAP_ERASE_TIME_US      = 50;
	localparam int          MAP_PROGRAM_TIME_US    = 50;
	localparam int          MAP_ERASE_CYCLES       = MAP_ERASE_TIME_US * 1000 / CLK_PERIOD_NS;
	localparam int          MAP_PROGRAM_CYCLES     = MAP_PROGRAM_TIME_US * 1000 / CLK_PERIOD_NS;

	// ****************************************
	// Carriers
	// ****************************************
	typedef struct packed {
		logic cs_n;
		logic sck;
		logic si;
		logic wp_n;
	} pins_s;

	typedef struct packed {
		logic       valid;
		logic [7:0] data;
	} byte_s;

endpackage

// >>> hdl/spm_sync.sv
`timescale 1ns/1ns
`default_nettype none
module spm_sync #(
	parameter int W = 4
) (
	input  wire logic         i_clk,
	input  wire logic         i_rst_n,
	input  wire logic [W-1:0] i_async,
	input  wire logic [W-1:0] i_reset_val,
	output logic      [W-1:0] o_sync
);
	logic [W-1:0] meta;
	logic [W-1:0] next_meta;
	logic [W-1:0] next_sync;

	always_comb begin
		next_meta = i_async;
		next_sync = meta;
	end

	// Reset value is a constant at every instance
	always_ff @(posedge i_clk or negedge i_rst_n) begin
		if (!i_rst_n) begin
			meta   <= '1;
			o_sync <= '1;
		end else begin
			meta   <= next_meta;
			o_sync <= next_sync;
		end
	end
endmodule // spm_sync
`default_nettype wire

// >>> hdl/spm_access.sv
`timescale 1ns/1ns
`default_nettype none
// Contract
// - Sixteen-byte map, byte n for sector n
// - All-ones byte marks sector protected
// - Sector 0 bits 7:6 and 5:4 split
// - Mixed byte value gives undefined protection
// - Erase opcode 3D 2A 7F CF
// - Busy during self-timed map erase
// - Erase accepted regardless of global protection
// - Program opcode then sixteen bytes, sector order
// - Program starts at release, busy meanwhile
// - Short program leaves missing bytes undefined
// - Excess program bytes wrap to zero
// - Program accepted regardless of global protection
// - Program uses and overwrites data buffer 1
// - Read opcode 32, three dummies, then map
// - Undefined output after sixteenth read byte
// - Release ends read, output tristated
// - Shipped map is all zeros
// - Marked sectors blocked only when protection enabled
// - Write-protect pin asserted blocks map change
module spm_access
	import spm_pkg::*;
#(
	parameter int ERASE_CYCLES   = MAP_ERASE_CYCLES,
	parameter int PROGRAM_CYCLES = MAP_PROGRAM_CYCLES
) (
	input  wire logic        I_MCLK,
	input  wire logic        I_RST_N,
	input  wire logic        I_CS_N,
	input  wire logic        I_SCK,
	input  wire logic        I_SI,
	input  wire logic        I_WP_N,
	input  wire logic        I_SW_PROT_EN,
	input  wire logic [3:0]  I_CHK_SECTOR,
	input  wire logic        I_CHK_SUB0B,
	output logic             O_SO,
	output logic             O_SO_OE_N,
	output logic             O_BUSY,
	output logic             O_SECTOR_BLOCKED,
	output logic [127:0]     O_MAP,
	output logic [127:0]     O_BUF1_LOW
);
	import spm_pkg::*;

	typedef enum {S_IDLE, S_OPCODE, S_PREFIX, S_DUMMY, S_READ, S_PROG, S_IGNORE} cmd_e;
	typedef enum {B_IDLE, B_ERASE, B_PROG} busy_e;

	// ****************************************
	// Pin synchronisation
	// ****************************************
	pins_s pins_raw;
	pins_s pins;
	assign pins_raw = '{cs_n: I_CS_N, sck: I_SCK, si: I_SI, wp_n: I_WP_N};

	spm_sync #(.W(4)) u_sync (
		.i_clk       (I_MCLK),
		.i_rst_n     (I_RST_N),
		.i_async     (pins_raw),
		.i_reset_val (4'hF),
		.o_sync      (pins)
	);

	// ****************************************
	// State
	// ****************************************
	logic                sck_d;
	logic                cs_d;
	cmd_e                st;
	busy_e               bst;
	logic [2:0]          bitcnt;
	logic [7:0]          shreg;
	logic [1:0]          prefix_idx;
	logic [1:0]          dummy_cnt;
	logic [4:0]          byte_idx;
	logic [3:0]          wr_ptr;
	logic [7:0]          out_byte;
	logic                so;
	logic                so_oe_n;
	logic [31:0]         busy_cnt;
	logic                pend_erase;
	logic                pend_prog;
	logic [7:0]          map [MAP_BYTES];
	logic [7:0]          buf1 [MAP_BYTES];

	logic                next_sck_d;
	logic                next_cs_d;
	cmd_e                next_st;
	busy_e               next_bst;
	logic [2:0]          next_bitcnt;
	logic [7:0]          next_shreg;
	logic [1:0]          next_prefix_idx;
	logic [1:0]          next_dummy_cnt;
	logic [4:0]          next_byte_idx;
	logic [3:0]          next_wr_ptr;
	logic [7:0]          next_out_byte;
	logic                next_so;
	logic                next_so_oe_n;
	logic [31:0]         next_busy_cnt;
	logic                next_pend_erase;
	logic                next_pend_prog;
	logic [7:0]          next_map [MAP_BYTES];
	logic [7:0]          next_buf1 [MAP_BYTES];

	logic                rise;
	logic                fall;
	logic                cs_act;
	logic                cs_rel;
	logic [7:0]          got_byte;
	logic                byte_done;
	logic [7:0]          prefix_byte;
	logic [7:0]          chk_byte;

	assign rise      = pins.sck & ~sck_d;
	assign fall      = ~pins.sck & sck_d;
	assign cs_act    = ~pins.cs_n;
	assign cs_rel    = pins.cs_n & ~cs_d;
	assign got_byte  = {shreg[6:0], pins.si};
	assign byte_done = cs_act && rise && (bitcnt == 3'd7);

	always_comb begin
		unique case (prefix_idx)
			2'd0:    prefix_byte = OP_PREFIX_0;
			2'd1:    prefix_byte = OP_PREFIX_1;
			default: prefix_byte = OP_PREFIX_2;
		endcase
	end

	// ****************************************
	// Serial command decode and map access
	// ****************************************
	always_comb begin
		next_sck_d      = pins.sck;
		next_cs_d       = pins.cs_n;
		next_st         = st;
		next_bst        = bst;
		next_bitcnt     = bitcnt;
		next_shreg      = shreg;
		next_prefix_idx = prefix_idx;
		next_dummy_cnt  = dummy_cnt;
		next_byte_idx   = byte_idx;
		next_wr_ptr     = wr_ptr;
		next_out_byte   = out_byte;
		next_so         = so;
		next_so_oe_n    = so_oe_n;
		next_busy_cnt   = busy_cnt;
		next_pend_erase = pend_erase;
		next_pend_prog  = pend_prog;
		next_map        = map;
		next_buf1       = buf1;

		if (!cs_act) begin
			next_st        = S_IDLE;
			next_bitcnt    = 3'd0;
			next_so_oe_n   = 1'b1;
		end else if (rise) begin
			next_bitcnt = bitcnt + 3'd1;
			next_shreg  = got_byte;
		end

		if (byte_done) begin
			unique case (st)
				S_IDLE, S_OPCODE: begin
					next_prefix_idx = 2'd0;
					if (bst != B_IDLE)
						next_st = S_IGNORE;
					else if (got_byte == OP_PREFIX_0) begin
						next_st         = S_PREFIX;
						next_prefix_idx = 2'd1;
					end else if (got_byte == OP_MAP_READ) begin
						next_st        = S_DUMMY;
						next_dummy_cnt = 2'd0;
					end else
						next_st = S_IGNORE;
				end
				S_PREFIX: begin
					if (prefix_idx != 2'd3) begin
						if (got_byte == prefix_byte)
							next_prefix_idx = prefix_idx + 2'd1;
						else
							next_st = S_IGNORE;
					end else if (got_byte == OP_MAP_ERASE) begin
						next_st         = S_IGNORE;
						next_pend_erase = 1'b1;
					end else if (got_byte == OP_MAP_PROGRAM) begin
						next_st       = S_PROG;
						next_wr_ptr   = 4'd0;
						next_byte_idx = 5'd0;
					end else
						next_st = S_IGNORE;
				end
				S_DUMMY: begin
					next_dummy_cnt = dummy_cnt + 2'd1;
					if (dummy_cnt == 2'(READ_DUMMIES - 1)) begin
						next_st       = S_READ;
						next_byte_idx = 5'd0;
						next_out_byte = map[0];
					end
				end
				S_PROG: begin
					// Buffer 1 is the staging store, old data is lost
					next_buf1[wr_ptr] = got_byte;
					next_wr_ptr       = wr_ptr + 4'd1;
					if (byte_idx != 5'(MAP_BYTES))
						next_byte_idx = byte_idx + 5'd1;
					next_pend_prog = 1'b1;
				end
				S_READ: begin
					next_byte_idx = byte_idx + 5'd1;
					// Past the last byte the output is don't-care: FF for seventeen bytes, then map bytes again once byte_idx wraps
					next_out_byte = (byte_idx < 5'(MAP_BYTES - 1))
						? map[4'(byte_idx + 5'd1)] : MAP_ERASED;
				end
				default: ;
			endcase
		end

		// Shift out MSB first on falling edges
		if (cs_act && st == S_READ && fall) begin
			next_so      = out_byte[3'd7 - bitcnt];
			next_so_oe_n = 1'b0;
		end

		// Write-protect asserted refuses map changes
		if (cs_rel && pins.wp_n) begin
			// No gating on global protection for map commands
			if (pend_erase) begin
				next_bst      = B_ERASE;
				next_busy_cnt = 32'(ERASE_CYCLES);
			end else if (pend_prog) begin
				next_bst      = B_PROG;
				next_busy_cnt = 32'(PROGRAM_CYCLES);
			end
		end
		if (cs_rel) begin
			next_pend_erase = 1'b0;
			next_pend_prog  = 1'b0;
		end

		if (bst != B_IDLE) begin
			if (busy_cnt > 32'd1)
				next_busy_cnt = busy_cnt - 32'd1;
			else begin
				next_bst = B_IDLE;
				for (int i = 0; i < MAP_BYTES; i++) begin
					if (bst == B_ERASE)
						next_map[i] = MAP_ERASED;
					// Only bits can clear; unsent bytes keep old map value
					else if (4'(i) < wr_ptr || byte_idx >= 5'(MAP_BYTES))
						next_map[i] = map[i] & buf1[i];
				end
			end
		end
	end

	// ****************************************
	// Protection lookup
	// ****************************************
	always_comb begin
		chk_byte = map[I_CHK_SECTOR];
		if (I_CHK_SECTOR == 4'd0)
			// Low nibble ignored for sector 0
			chk_byte = I_CHK_SUB0B ? {8{&chk_byte[SUB0B_HI:SUB0B_LO]}}
				: {8{&chk_byte[SUB0A_HI:SUB0A_LO]}};
		// Mixed values resolve by their top bit, sector 0 pairs by both bits, not guaranteed
		O_SECTOR_BLOCKED = chk_byte[7] & (I_SW_PROT_EN | ~pins.wp_n);
	end

	always_comb begin
		for (int i = 0; i < MAP_BYTES; i++) begin
			O_MAP[i*8 +: 8]      = map[i];
			O_BUF1_LOW[i*8 +: 8] = buf1[i];
		end
	end

	assign O_SO      = so;
	assign O_SO_OE_N = so_oe_n;
	assign O_BUSY    = (bst != B_IDLE);

	always_ff @(posedge I_MCLK or negedge I_RST_N) begin
		if (!I_RST_N) begin
			sck_d      <= 1'b1;
			cs_d       <= 1'b1;
			st         <= S_IDLE;
			bst        <= B_IDLE;
			bitcnt     <= 3'd0;
			shreg      <= 8'h00;
			prefix_idx <= 2'd0;
			dummy_cnt  <= 2'd0;
			byte_idx   <= 5'd0;
			wr_ptr     <= 4'd0;
			out_byte   <= 8'h00;
			so         <= 1'b0;
			so_oe_n    <= 1'b1;
			busy_cnt   <= 32'd0;
			pend_erase <= 1'b0;
			pend_prog  <= 1'b0;
			for (int i = 0; i < MAP_BYTES; i++) begin
				map[i]  <= MAP_SHIPPED;
				buf1[i] <= 8'h00;
			end
		end else begin
			sck_d      <= next_sck_d;
			cs_d       <= next_cs_d;
			st         <= next_st;
			bst        <= next_bst;
			bitcnt     <= next_bitcnt;
			shreg      <= next_shreg;
			prefix_idx <= next_prefix_idx;
			dummy_cnt  <= next_dummy_cnt;
			byte_idx   <= next_byte_idx;
			wr_ptr     <= next_wr_ptr;
			out_byte   <= next_out_byte;
			so         <= next_so;
			so_oe_n    <= next_so_oe_n;
			busy_cnt   <= next_busy_cnt;
			pend_erase <= next_pend_erase;
			pend_prog  <= next_pend_prog;
			map        <= next_map;
			buf1       <= next_buf1;
		end
	end
endmodule // spm_access
`default_nettype wire

// >>> sim/spm_host.sv
`timescale 1ns/1ns
`default_nettype none
module spm_host
	import spm_pkg::*;
(
	output logic		o_cs_n,
	output logic		o_sck,
	output logic		o_si,
	input  wire logic	i_so,
	output byte_s		o_rx
);
	import spm_pkg::*;
	// ****
	// Serial host, mode 0, 125 ns link period
	// ****
	initial begin
		o_cs_n = 1'b1;
		o_sck = 1'b0;
		o_si = 1'b0;
		o_rx = '0;
	end
	// Clock rests low between frames; the gap also covers the device's pin sync
	// Odd offset keeps pin edges off system clock edges, except where the 1 ns steps after read-back bytes add up
	task automatic sel(input logic on);
		#101;
		o_cs_n = !on;
		o_si = !o_si;
	endtask
	task automatic xfer(input logic [7:0] tx, input logic keep);
		logic [7:0] r;
		for (int i = 7; i >= 0; i--) begin
			o_si = tx[i];
			#62 o_sck = 1'b1;
			r[i] = i_so;
			#63 o_sck = 1'b0;
		end
		if (keep) begin
			o_rx = {1'b1, r};
			#1 o_rx.valid = 1'b0;
		end
	endtask
endmodule // spm_host
`default_nettype wire

// >>> sim/spm_access_chk.sv
`timescale 1ns/1ns
`default_nettype none
module spm_access_chk #(
	parameter int ERASE_CYCLES	= 20,
	parameter int PROGRAM_CYCLES	= 20
) (
	input wire logic		I_MCLK,
	input wire logic		I_RST_N,
	input wire logic		I_CS_N,
	input wire logic		I_SCK,
	input wire logic		I_SI,
	input wire logic		I_WP_N,
	input wire logic		I_SW_PROT_EN,
	input wire logic [3:0]		I_CHK_SECTOR,
	input wire logic		I_CHK_SUB0B,
	input wire logic		O_SO,
	input wire logic		O_SO_OE_N,
	input wire logic		O_BUSY,
	input wire logic		O_SECTOR_BLOCKED,
	input wire logic [127:0]	O_MAP,
	input wire logic [127:0]	O_BUF1_LOW
);
	// ****
	// Busy length counter
	// ****
	int busy_len;
	int next_busy_len;
	default clocking @(posedge I_MCLK); endclocking
	default disable iff (!I_RST_N);
	always_comb next_busy_len = O_BUSY ? busy_len + 1 : 0;
	always_ff @(posedge I_MCLK or negedge I_RST_N) begin
		if (!I_RST_N)
			busy_len <= 0;
		else
			busy_len <= next_busy_len;
	end
	busy_length_a: assert property (
		$fell(O_BUSY) |-> busy_len == ERASE_CYCLES || busy_len == PROGRAM_CYCLES)
		else $error("Busy period has the wrong length");
	map_commit_a: assert property (
		$changed(O_MAP) |-> $past(O_BUSY) || $past(O_BUSY, 2))
		else $error("Map changed outside a busy period");
	map_bits_a: assert property (
		$changed(O_MAP) |-> O_MAP == '1 || (O_MAP & ~$past(O_MAP)) == '0)
		else $error("Map gained bits without an erase");
	oe_idle_a: assert property (I_CS_N [*5] |-> O_SO_OE_N)
		else $error("Output driven while deselected");
	oe_select_a: assert property ($fell(O_SO_OE_N) |-> !I_CS_N)
		else $error("Output enabled without select");
	busy_quiet_a: assert property (O_BUSY |-> O_SO_OE_N)
		else $error("Output driven while busy");
	blk_off_a: assert property (
		(!I_SW_PROT_EN && I_WP_N) [*4] |-> !O_SECTOR_BLOCKED)
		else $error("Sector blocked with protection off");
	blk_map_a: assert property (
		I_SW_PROT_EN && I_CHK_SECTOR != 4'h0 |->
		O_SECTOR_BLOCKED == O_MAP[8*I_CHK_SECTOR+7])
		else $error("Sector block differs from map");
	blk_sub0_a: assert property (
		I_SW_PROT_EN && I_CHK_SECTOR == 4'h0 |->
		O_SECTOR_BLOCKED == (I_CHK_SUB0B ? &O_MAP[5:4] : &O_MAP[7:6]))
		else $error("Sector zero half block wrong");
endmodule // spm_access_chk
bind spm_access spm_access_chk #(
	.ERASE_CYCLES(ERASE_CYCLES),
	.PROGRAM_CYCLES(PROGRAM_CYCLES)
) chk_u (
	.I_MCLK(I_MCLK), .I_RST_N(I_RST_N), .I_CS_N(I_CS_N), .I_SCK(I_SCK), .I_SI(I_SI),
	.I_WP_N(I_WP_N), .I_SW_PROT_EN(I_SW_PROT_EN), .I_CHK_SECTOR(I_CHK_SECTOR),
	.I_CHK_SUB0B(I_CHK_SUB0B), .O_SO(O_SO), .O_SO_OE_N(O_SO_OE_N), .O_BUSY(O_BUSY),
	.O_SECTOR_BLOCKED(O_SECTOR_BLOCKED), .O_MAP(O_MAP), .O_BUF1_LOW(O_BUF1_LOW));
`default_nettype wire

// >>> sim/test_sector_protect_map_access.sv
`timescale 1ns/1ns
`default_nettype none
module test_sector_protect_map_access;
	import spm_pkg::*;
	// ****
	// Bench
	// ****
	localparam int CYC = 20;
	logic		clk, rst_n, wp_n, prot, sub0b, cs_n, sck, si, so, oe_n, busy, blk;
	logic [3:0]	sect;
	logic [127:0]	map, buf1, m_e, buf_e, dat;
	logic [7:0]	lfsr = 8'h48;
	logic [7:0]	exp_q[$];
	byte_s		rx;
	int		err_count, num_checks;
	wire logic	so_w = oe_n ? 1'bz : so;
	spm_access #(.ERASE_CYCLES(CYC), .PROGRAM_CYCLES(CYC)) dut_u (
		.I_MCLK(clk), .I_RST_N(rst_n), .I_CS_N(cs_n), .I_SCK(sck), .I_SI(si),
		.I_WP_N(wp_n), .I_SW_PROT_EN(prot), .I_CHK_SECTOR(sect), .I_CHK_SUB0B(sub0b),
		.O_SO(so), .O_SO_OE_N(oe_n), .O_BUSY(busy), .O_SECTOR_BLOCKED(blk),
		.O_MAP(map), .O_BUF1_LOW(buf1));
	spm_host host_u (.o_cs_n(cs_n), .o_sck(sck), .o_si(si), .i_so(so_w), .o_rx(rx));
	function automatic logic [7:0] rnd();
		lfsr = {lfsr[6:0], ^(lfsr & 8'hB8)};
		return lfsr;
	endfunction
	task automatic check(input logic [127:0] seen, input logic [127:0] exp);
		num_checks++;
		if (seen !== exp) begin
			err_count++;
			$display("ERROR t=%0t seen=%0h exp=%0h", $time, seen, exp);
		end
	endtask
	task automatic stop_test();
		if (err_count == 0 && num_checks > 0)
			$display("All tests passed");
		else
			$display("Some tests failed");
		$finish;
	endtask
	task automatic run(input logic [7:0] op, input int n, input logic [127:0] d,
			input logic ok);
		int c;
		logic [7:0] v;
		logic [127:0] b;
		b = buf_e;
		host_u.sel(1'b1);
		host_u.xfer(OP_PREFIX_0, 1'b0);
		host_u.xfer(OP_PREFIX_1, 1'b0);
		host_u.xfer(OP_PREFIX_2, 1'b0);
		host_u.xfer(op, 1'b0);
		for (int k = 0; k < n; k++) begin
			v = k < MAP_BYTES ? d[8*k+:8] : rnd();
			b[8*(k%MAP_BYTES)+:8] = v;
			host_u.xfer(v, 1'b0);
		end
		host_u.sel(1'b0);
		c = 0;
		repeat (12) if (!busy) @(negedge clk);
		while (busy && c < 1000) begin
			c++;
			@(negedge clk);
		end
		repeat (2) @(negedge clk);
		check(128'(busy), 128'(0));
		check(128'(c), ok ? 128'(CYC) : '0);
		if (ok && op == OP_MAP_ERASE)
			m_e = '1;
		for (int k = 0; ok && k < n && k < MAP_BYTES; k++)
			m_e[8*k+:8] &= b[8*k+:8];
		check(map, m_e);
		// Buffer is overwritten even when the map change is refused
		buf_e = b;
		check(buf1, buf_e);
	endtask
	// The seventeenth byte, read past the map, comes back as all ones
	task automatic rd_map();
		host_u.sel(1'b1);
		host_u.xfer(OP_MAP_READ, 1'b0);
		repeat (READ_DUMMIES) host_u.xfer(rnd(), 1'b0);
		for (int k = 0; k <= MAP_BYTES; k++) begin
			exp_q.push_back(k < MAP_BYTES ? m_e[8*k+:8] : 8'hFF);
			host_u.xfer(rnd(), 1'b1);
		end
		host_u.sel(1'b0);
	endtask
	// Six cycles let the write-protect pin through its synchroniser
	task automatic probe(input logic [3:0] s, input logic b, input logic p, input logic w);
		logic e;
		@(negedge clk);
		sect = s;
		sub0b = b;
		prot = p;
		wp_n = w;
		repeat (6) @(negedge clk);
		e = (p || !w) && (s == 4'h0 ? (b ? &m_e[5:4] : &m_e[7:6]) : m_e[8*s+7]);
		check(128'(blk), 128'(e));
	endtask
	initial begin
		clk = 1'b0;
		forever #5 clk = ~clk;
	end
	initial forever begin
		@(posedge rx.valid);
		check(128'(rx.data), 128'(exp_q.pop_front()));
	end
	// Run is about a hundred microseconds; limit is four times that
	initial begin
		#400000;
		err_count++;
		stop_test();
	end
	initial begin
		{rst_n, prot, sub0b, sect} = '0;
		wp_n = 1'b1;
		m_e = '0;
		buf_e = '0;
		repeat (4) @(negedge clk);
		rst_n = 1'b1;
		repeat (4) @(negedge clk);
		check(map, m_e);
		rd_map();
		@(negedge clk);
		prot = 1'b1;
		run(OP_MAP_ERASE, 0, '0, 1'b1);
		for (int k = 0; k < MAP_BYTES; k++)
			dat[8*k+:8] = rnd();
		run(OP_MAP_PROGRAM, 17, dat, 1'b1);
		rd_map();
		@(negedge clk);
		prot = 1'b0;
		wp_n = 1'b0;
		run(OP_MAP_ERASE, 0, '0, 1'b0);
		run(OP_MAP_PROGRAM, 16, '0, 1'b0);
		@(negedge clk);
		wp_n = 1'b1;
		run(OP_MAP_ERASE, 0, '0, 1'b1);
		run(OP_MAP_PROGRAM, 2, {112'h0, 8'h17, 8'h3F}, 1'b1);
		probe(4'h0, 1'b0, 1'b1, 1'b1);
		probe(4'h0, 1'b1, 1'b1, 1'b1);
		probe(4'h2, 1'b0, 1'b1, 1'b1);
		probe(4'h2, 1'b0, 1'b0, 1'b0);
		probe(4'h2, 1'b0, 1'b0, 1'b1);
		stop_test();
	end
endmodule // test_sector_protect_map_access
`default_nettype wire
